// File: rtl/hpsm_regs.svh
// Purpose: constants for the hub port pin and strap mux
// Assumes: core clock of 50 MHz
// Notes: strap window measured from reset release
`ifndef HPSM_REGS_SVH
`define HPSM_REGS_SVH

// -----------------------------------------------------------------------
// timing
// -----------------------------------------------------------------------
`define HPSM_CLK_HZ 50000000
`define HPSM_STRAP_HOLD_MS 60
`define HPSM_STRAP_HOLD_CYC (`HPSM_CLK_HZ / 1000 * `HPSM_STRAP_HOLD_MS)
`define HPSM_CNT_W 22

// -----------------------------------------------------------------------
// reset values
// -----------------------------------------------------------------------
`define HPSM_STRAP_RST 1'b0
`define HPSM_POL_RST 1'b0

`endif

// File: rtl/hpsm_pkg.sv
// Purpose: types for the hub port pin and strap mux
// Assumes: nothing
// Notes: pin owner selection
package hpsm_pkg;
  // what the shared pins currently do
  typedef enum logic [1:0] {
    HPSM_FN_LED,
    HPSM_FN_SPI,
    HPSM_FN_I2C
  } hpsm_fn_t;

  // strap phase
  typedef enum logic [1:0] {
    HPSM_PH_SAMPLE,
    HPSM_PH_HOLD,
    HPSM_PH_RUN
  } hpsm_phase_t;
endpackage : hpsm_pkg

// File: rtl/hpsm_pin_mux.sv
// Purpose: shared pin mux and strap capture for ports 1 and 2
// Assumes: inputs from pins; eeprom engine and hub core on core_clk
// Notes: pins stay inputs until the strap hold window ends
//
// What this block does
// - test input 0 normal, 1 test mode
// - test pin doubles as i2c clock
// - port 1 power pin doubles as i2c data
// - spi select and clock on port 1 leds
// - spi data out/in on port 2 leds
// - two active-high leds per port
// - sample straps, outputs after 60 ms
// - fixed-port strap marks port non-removable
// - overcurrent inputs active low
// - power switch output tristatable, active low while the polarity strap is low
// - polarity strap sets power enable level
// - external reset returns everything to initial
`timescale 1ns/1ps
`include "hpsm_regs.svh"

module hpsm_pin_mux #(
  // strap hold length in core clocks; benches may shorten it
  parameter int STRAP_HOLD_CYC = `HPSM_STRAP_HOLD_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // hub core side
  input wire logic [1:0] pin_fn_sel,
  input wire logic [1:0] led_fault_req,
  input wire logic [1:0] led_ok_req,
  input wire logic [1:0] port_power_req,
  output logic [1:0] port_overcurrent,
  output logic [1:0] port_nonremovable,
  output logic test_mode,
  output logic pins_released,
  // eeprom engine side
  input wire logic spi_cs_req,
  input wire logic spi_sck_req,
  input wire logic spi_mosi_req,
  output logic spi_miso_data,
  input wire logic i2c_scl_oe_req,
  input wire logic i2c_sda_oe_req,
  output logic i2c_scl_data,
  output logic i2c_sda_data,
  // test / i2c clock pin
  input wire logic test_scl_in,
  output logic test_scl_out,
  output logic test_scl_oe,
  // port 1 pins
  input wire logic p1_fault_in,
  output logic p1_fault_out,
  output logic p1_fault_oe,
  input wire logic p1_ok_in,
  output logic p1_ok_out,
  output logic p1_ok_oe,
  input wire logic nonremovable_strap_p1,
  input wire logic [1:0] overcurrent_n,
  input wire logic p1_power_in,
  output logic [1:0] port_power_switch_en,
  output logic [1:0] port_power_switch_oe,
  // port 2 pins
  input wire logic p2_fault_in,
  output logic p2_fault_out,
  output logic p2_fault_oe,
  input wire logic p2_ok_in,
  output logic p2_ok_out,
  output logic p2_ok_oe
);

  // -----------------------------------------------------------------------
  // pin synchronisers
  // -----------------------------------------------------------------------
  logic [6:0] pin_meta_reg;
  logic [6:0] pin_sync_reg;
  logic [6:0] pin_raw;
  logic [1:0] ovc_meta_reg;
  logic [1:0] ovc_sync_reg;

  assign pin_raw = {nonremovable_strap_p1, test_scl_in, p1_fault_in,
                    p1_ok_in, p2_fault_in, p2_ok_in, p1_power_in};

  // two flops on every pin input
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_meta_reg <= 7'h00;
      pin_sync_reg <= 7'h00;
      ovc_meta_reg <= 2'h3;
      ovc_sync_reg <= 2'h3;
    end else begin
      pin_meta_reg <= pin_raw;
      pin_sync_reg <= pin_meta_reg;
      ovc_meta_reg <= overcurrent_n;
      ovc_sync_reg <= ovc_meta_reg;
    end
  end

  logic fix1_s, test_s, p2_ok_s, p2_fault_s, p1_sda_s;
  assign fix1_s = pin_sync_reg[6];
  assign test_s = pin_sync_reg[5];
  assign p2_fault_s = pin_sync_reg[2];
  assign p2_ok_s = pin_sync_reg[1];
  assign p1_sda_s = pin_sync_reg[0];

  // -----------------------------------------------------------------------
  // strap phase and hold counter
  // -----------------------------------------------------------------------
  hpsm_pkg::hpsm_phase_t phase_reg;
  logic [`HPSM_CNT_W-1:0] hold_cnt_reg;
  localparam logic [`HPSM_CNT_W-1:0] HOLD_LAST =
    `HPSM_CNT_W'(STRAP_HOLD_CYC - 1);

  // sample once syncs are full, then wait 60 ms before driving
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase_reg <= hpsm_pkg::HPSM_PH_SAMPLE;
      hold_cnt_reg <= '0;
    end else begin
      unique case (phase_reg)
        hpsm_pkg::HPSM_PH_SAMPLE: begin
          if (hold_cnt_reg == `HPSM_CNT_W'(2)) begin
            phase_reg <= hpsm_pkg::HPSM_PH_HOLD;
            hold_cnt_reg <= '0;
          end else begin
            hold_cnt_reg <= hold_cnt_reg + `HPSM_CNT_W'(1);
          end
        end
        hpsm_pkg::HPSM_PH_HOLD: begin
          if (hold_cnt_reg == HOLD_LAST) begin
            phase_reg <= hpsm_pkg::HPSM_PH_RUN;
          end else begin
            hold_cnt_reg <= hold_cnt_reg + `HPSM_CNT_W'(1);
          end
        end
        hpsm_pkg::HPSM_PH_RUN: begin
          hold_cnt_reg <= hold_cnt_reg;
        end
      endcase
    end
  end

  logic run;
  assign run = (phase_reg == hpsm_pkg::HPSM_PH_RUN);
  assign pins_released = run;

  // -----------------------------------------------------------------------
  // strap capture, held until the next reset
  // -----------------------------------------------------------------------
  logic test_reg;
  logic pol_reg;
  logic [1:0] fixed_reg;
  logic capture;
  assign capture = (phase_reg == hpsm_pkg::HPSM_PH_SAMPLE) &&
                   (hold_cnt_reg == `HPSM_CNT_W'(2));

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      test_reg <= `HPSM_STRAP_RST;
      pol_reg <= `HPSM_POL_RST;
      fixed_reg <= 2'h0;
    end else if (capture) begin
      test_reg <= test_s;
      pol_reg <= p2_fault_s;
      fixed_reg <= {p2_ok_s, fix1_s};
    end
  end

  assign test_mode = test_reg;
  assign port_nonremovable = fixed_reg;

  // -----------------------------------------------------------------------
  // function select, decoded combinationally from pin_fn_sel only while running
  // -----------------------------------------------------------------------
  hpsm_pkg::hpsm_fn_t fn;
  always_comb begin
    if (!run) begin
      fn = hpsm_pkg::HPSM_FN_LED;
    end else begin
      unique case (pin_fn_sel)
        2'h1: fn = hpsm_pkg::HPSM_FN_SPI;
        2'h2: fn = hpsm_pkg::HPSM_FN_I2C;
        default: fn = hpsm_pkg::HPSM_FN_LED;
      endcase
    end
  end

  logic spi_on, i2c_on;
  assign spi_on = (fn == hpsm_pkg::HPSM_FN_SPI);
  assign i2c_on = (fn == hpsm_pkg::HPSM_FN_I2C);

  // -----------------------------------------------------------------------
  // registered pin outputs
  // -----------------------------------------------------------------------
  logic [3:0] led_out_reg;
  logic [3:0] led_oe_reg;
  logic scl_oe_reg;
  logic [1:0] pwr_reg;
  logic [1:0] pwr_oe_reg;

  // leds active high; spi takes port 1 leds and port 2 fault pin
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      led_out_reg <= 4'h0;
      led_oe_reg <= 4'h0;
    end else if (!run) begin
      led_out_reg <= 4'h0;
      led_oe_reg <= 4'h0;
    end else if (spi_on) begin
      led_out_reg <= {spi_cs_req, spi_sck_req, spi_mosi_req, 1'b0};
      led_oe_reg <= 4'hE;
    end else begin
      led_out_reg <= {led_fault_req[0], led_ok_req[0],
                      led_fault_req[1], led_ok_req[1]};
      led_oe_reg <= 4'hF;
    end
  end

  assign {p1_fault_out, p1_ok_out, p2_fault_out, p2_ok_out} = led_out_reg;
  assign {p1_fault_oe, p1_ok_oe, p2_fault_oe, p2_ok_oe} = led_oe_reg;

  // i2c clock open drain on test pin
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_oe_reg <= 1'b0;
    end else begin
      scl_oe_reg <= i2c_on && i2c_scl_oe_req;
    end
  end
  assign test_scl_out = 1'b0;
  assign test_scl_oe = scl_oe_reg;

  // power switch drivers; level per polarity strap, high-z until run
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pwr_reg <= 2'h0;
      pwr_oe_reg <= 2'h0;
    end else if (!run) begin
      pwr_reg <= 2'h0;
      pwr_oe_reg <= 2'h0;
    end else begin
      pwr_reg <= pol_reg ? port_power_req : ~port_power_req;
      pwr_oe_reg <= 2'h3;
      if (i2c_on) begin
        pwr_reg[0] <= 1'b0;
        pwr_oe_reg[0] <= i2c_sda_oe_req;
      end
    end
  end
  assign port_power_switch_en = pwr_reg;
  assign port_power_switch_oe = pwr_oe_reg;

  // -----------------------------------------------------------------------
  // inputs back to core and eeprom engine
  // -----------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      port_overcurrent <= 2'h0;
      spi_miso_data <= 1'b0;
      i2c_scl_data <= 1'b1;
      i2c_sda_data <= 1'b1;
    end else begin
      port_overcurrent <= ~ovc_sync_reg;
      spi_miso_data <= spi_on ? p2_ok_s : 1'b0;
      i2c_scl_data <= i2c_on ? test_s : 1'b1;
      i2c_sda_data <= i2c_on ? p1_sda_s : 1'b1;
    end
  end

endmodule : hpsm_pin_mux

// File: dv/hpsm_pin_mux_sva.sv
// Purpose: port checks for the pin and strap mux
// Assumes: top ports only, one clock domain
// Notes: hold count passed in from the bound instance
`timescale 1ns/1ps
`include "hpsm_regs.svh"
module hpsm_pin_mux_sva #(
  parameter int HOLD_CYC = `HPSM_STRAP_HOLD_CYC
) (
  // clock, reset, core side
  input wire logic core_clk, sys_rst, test_mode, pins_released,
  input wire logic [1:0] pin_fn_sel, led_fault_req, overcurrent_n,
  input wire logic [1:0] port_overcurrent, port_nonremovable,
  input wire logic [1:0] port_power_switch_oe,
  // engine and pin side
  input wire logic spi_cs_req, spi_sck_req, spi_mosi_req, i2c_scl_oe_req,
  input wire logic i2c_sda_oe_req, test_scl_oe, p1_fault_out, p1_fault_oe,
  input wire logic p1_ok_out, p2_fault_out, p2_ok_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  int unsigned cnt;
  // cycles since reset release, saturating
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) cnt <= 0;
    else if (cnt < 4000000) cnt <= cnt + 1;
  end
  sequence s_run(logic [1:0] fn);
    pins_released && pin_fn_sel == fn;
  endsequence
  a_release_time: assert property ($rose(pins_released) |->
    cnt >= HOLD_CYC && cnt < HOLD_CYC + 10)
    else $error("release time off");
  a_pins_quiet: assert property (!pins_released |->
    !(p1_fault_oe | p2_ok_oe | test_scl_oe | (|port_power_switch_oe)))
    else $error("pin driven before release");
  a_oc_level: assert property ($stable(overcurrent_n) [*5] |->
    port_overcurrent == ~overcurrent_n) else $error("overcurrent level");
  a_straps_held: assert property (pins_released |->
    $stable(port_nonremovable) && $stable(test_mode))
    else $error("strap changed");
  a_led_map: assert property (s_run(2'h0) |=>
    p1_fault_out == $past(led_fault_req[0]) && p1_fault_oe)
    else $error("led pin wrong");
  a_spi_map: assert property (s_run(2'h1) |=>
    {p1_fault_out, p1_ok_out, p2_fault_out, p2_ok_oe} == {$past(spi_cs_req),
    $past(spi_sck_req), $past(spi_mosi_req), 1'b0}) else $error("spi pin");
  a_i2c_map: assert property (s_run(2'h2) |=>
    test_scl_oe == $past(i2c_scl_oe_req) &&
    port_power_switch_oe[0] == $past(i2c_sda_oe_req)) else $error("i2c pin");
  a_reset_init: assert property ($fell(sys_rst) |-> !pins_released &&
    !test_mode && port_nonremovable == 2'h0 && port_overcurrent == 2'h0)
    else $error("state not initial");
endmodule : hpsm_pin_mux_sva

// File: dv/hpsm_far_side.sv
// Purpose: strap resistors, eeprom and switch pins
// Assumes: bench sets strap and eeprom levels
// Notes: released pins fall to their pull level
`timescale 1ns/1ps
module hpsm_far_side (
  // bench controls
  input wire logic strap_on, miso_bit, sda_low,
  input wire logic [3:0] strap_val,
  // hub pins
  input wire logic test_scl_oe, test_scl_out, p1_fault_out, p1_fault_oe,
  input wire logic p1_ok_out, p1_ok_oe, p2_fault_out, p2_fault_oe,
  input wire logic p2_ok_out, p2_ok_oe,
  input wire logic [1:0] port_power_switch_oe, port_power_switch_en,
  // levels back to the hub
  output logic test_scl_in, nonremovable_strap_p1, p1_power_in,
  output logic p1_fault_in, p1_ok_in, p2_fault_in, p2_ok_in
);
  // straps hold until released, then pull-downs or bus pull-ups; the fixed1 strap is never released
  assign test_scl_in = strap_on ? strap_val[0] :
    !(test_scl_oe && !test_scl_out);
  assign nonremovable_strap_p1 = strap_val[1];
  assign p1_fault_in = p1_fault_oe & p1_fault_out;
  assign p1_ok_in = p1_ok_oe & p1_ok_out;
  assign p2_fault_in = p2_fault_oe ? p2_fault_out : strap_on & strap_val[2];
  // eeprom data in on the port 2 ok pin
  assign p2_ok_in = p2_ok_oe ? p2_ok_out : strap_on ? strap_val[3] : miso_bit;
  // open-drain data line, low if either side pulls
  assign p1_power_in = !(port_power_switch_oe[0] &&
    !port_power_switch_en[0]) && !sda_low;
endmodule : hpsm_far_side

// File: dv/hub_port_pin_strap_mux_bench.sv
// Purpose: bench for the pin and strap mux
// Assumes: strap hold shortened to HOLD cycles
// Notes: strap bits are test, fixed1, polarity, fixed2
`timescale 1ns/1ps
module hub_port_pin_strap_mux_bench;
  logic core_clk = 0, sys_rst = 1, pins_released, test_mode;
  logic spi_cs_req = 0, spi_sck_req = 0, spi_mosi_req = 0, spi_miso_data;
  logic i2c_scl_oe_req = 0, i2c_sda_oe_req = 0, i2c_scl_data, i2c_sda_data;
  logic [1:0] pin_fn_sel = 0, led_fault_req = 0, led_ok_req = 0;
  logic [1:0] port_power_req = 0, overcurrent_n = 2'h3, port_overcurrent;
  logic [1:0] port_nonremovable, port_power_switch_en, port_power_switch_oe;
  logic test_scl_in, test_scl_out, test_scl_oe, nonremovable_strap_p1;
  logic p1_fault_in, p1_fault_out, p1_fault_oe, p1_ok_in, p1_ok_out, p1_ok_oe;
  logic p2_fault_in, p2_fault_out, p2_fault_oe, p2_ok_in, p2_ok_out, p2_ok_oe;
  logic p1_power_in, strap_on = 1, miso_bit = 0, sda_low = 0;
  logic [3:0] strap_val = 4'h0;
  int n_fail = 0, num_checks = 0;
  // short strap hold keeps the run brief
  localparam int HOLD = 1000;
  hpsm_pin_mux #(.STRAP_HOLD_CYC(HOLD)) DUT (.*);
  hpsm_far_side far (.*);
  initial forever #10 core_clk = ~core_clk;
  task cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc
  task chk(input logic [7:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task stop_test;
    if (n_fail == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  // reset with a strap pattern, read captured straps, pulse overcurrent
  task t_straps(input logic [3:0] s, input logic [2:0] exp);
    strap_val = s;
    strap_on = 1'b1;
    sys_rst = 1'b1;
    cyc(20);
    sys_rst = 1'b0;
    cyc(5);
    chk({test_mode, port_nonremovable}, exp);
    strap_on = 1'b0;
    overcurrent_n = 2'h2;
    cyc(4);
    chk(port_overcurrent, 2'h1);
    overcurrent_n = 2'h3;
  endtask : t_straps
  // wait for the hold window to end, then one more edge for the pins
  task wait_run;
    for (int i = 0; i < HOLD + 100 && pins_released !== 1'b1; i++) cyc(1);
    cyc(1);
  endtask : wait_run
  // wait out the hold, then each pin function in turn
  task t_functions;
    wait_run;
    chk({p1_fault_oe, p2_ok_oe, port_power_switch_oe}, 4'hF);
    led_fault_req = 2'h1;
    led_ok_req = 2'h2;
    port_power_req = 2'h2;
    cyc(2);
    chk({p1_fault_out, p1_ok_out, p2_fault_out, p2_ok_out}, 4'h9);
    chk(port_power_switch_en, 2'h1);
    pin_fn_sel = 2'h1;
    spi_cs_req = 1'b1;
    spi_mosi_req = 1'b1;
    miso_bit = 1'b1;
    cyc(6);
    chk({p1_fault_out, p1_ok_out, p2_fault_out, spi_miso_data},
      4'hB);
    spi_sck_req = 1'b1;
    miso_bit = 1'b0;
    cyc(4);
    chk({p1_ok_out, spi_miso_data}, 2'h2);
    pin_fn_sel = 2'h2;
    i2c_scl_oe_req = 1'b1;
    sda_low = 1'b1;
    cyc(6);
    chk({test_scl_oe, i2c_scl_data, i2c_sda_data}, 3'h4);
    i2c_scl_oe_req = 1'b0;
    i2c_sda_oe_req = 1'b1;
    sda_low = 1'b0;
    cyc(6);
    chk({test_scl_oe, i2c_scl_data}, 2'h1);
    chk({port_power_switch_oe[0], i2c_sda_data}, 2'h2);
    sys_rst = 1'b1;
    cyc(1);
    chk({pins_released, p1_fault_oe, test_scl_oe}, 3'h0);
  endtask : t_functions
  // polarity strap high: enables follow the requests, straps stay put
  task t_polarity;
    pin_fn_sel = 2'h0;
    port_power_req = 2'h1;
    t_straps(4'h6, 3'h1);
    wait_run;
    chk(port_power_switch_en, 2'h1);
    chk({test_mode, port_nonremovable}, 3'h1);
  endtask : t_polarity
  initial begin
    t_straps(4'h7, 3'h5);
    t_straps(4'h8, 3'h2);
    t_functions;
    t_polarity;
    stop_test;
  end
  // watchdog past the hold window
  initial begin
    #100000;
    n_fail++;
    stop_test;
  end
endmodule : hub_port_pin_strap_mux_bench
bind hpsm_pin_mux hpsm_pin_mux_sva #(.HOLD_CYC(STRAP_HOLD_CYC)) chk_i (.*);
